// *** rtl/eep_core.sv ***
// Serial EEPROM slave top: link engine clocked by the serial clock,
// bus condition watch and programming control on the system clock.
// Assumes the data wire is resolved outside from o_sda_oe with a pull-up,
// and that the serial clock stands still while the bus is idle.
`timescale 1ns/1ns

module eep_core
  import eep_pkg::*;
#(
  parameter int unsigned P_TWR_CYC = TWR_CYC,
  parameter int unsigned ADDR_W    = ADDR_W_DEF
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_wp,
  input  wire logic i_supply_low,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  output logic      o_busy
);

  // ----------------------------------------------------------------
  // System clock domain: pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [1:0] wp_s_q;
  logic [1:0] low_s_q;
  logic       link_hold_q;
  logic       stop_q;
  logic       busy_out_q;
  logic       sda_o_q;

  // Bundle to the programming controller, declared before its first use
  eep_prog_if #(.ADDR_W(ADDR_W)) pif ();

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      wp_s_q  <= 2'h0;
      low_s_q <= 2'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
      wp_s_q  <= {wp_s_q[0], i_wp};
      low_s_q <= {low_s_q[0], i_supply_low};
    end
  end

  // ----------------------------------------------------------------
  // System clock domain: START and STOP watch
  // ----------------------------------------------------------------
  // Stage 1 may still be unsettled; only stages 2 and 3 are compared.
  wire scl_high = scl_s_q[1] & scl_s_q[2];
  wire start_p  = scl_high & sda_s_q[2] & ~sda_s_q[1];
  wire stop_p   = scl_high & ~sda_s_q[2] & sda_s_q[1];

  // The link engine's frame state and pin drive are held in reset from STOP until the next START,
  // so its data pin drive does not outlive the frame even though its clock then stops.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link_hold_q <= 1'b1;
    end else if (stop_p) begin
      link_hold_q <= 1'b1;
    end else if (start_p) begin
      link_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_q     <= 1'b0;
      busy_out_q <= 1'b0;
      sda_o_q    <= 1'b0;
    end else begin
      stop_q     <= stop_p;
      busy_out_q <= pif.busy;
      sda_o_q    <= 1'b0;
    end
  end

  assign o_sda_o = sda_o_q;
  assign o_busy  = busy_out_q;

  // ----------------------------------------------------------------
  // Programming controller
  // ----------------------------------------------------------------
  assign pif.stop       = stop_q;
  assign pif.wp         = wp_s_q[1];
  assign pif.supply_low = low_s_q[1];

  eep_prog #(
    .P_TWR_CYC (P_TWR_CYC),
    .ADDR_W    (ADDR_W)
  ) u_prog (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .pif       (pif)
  );

  // ----------------------------------------------------------------
  // Serial clock domain: registers
  // ----------------------------------------------------------------
  eep_state_t        state_q;
  eep_state_t        state_d;
  logic [2:0]        cnt_q;
  logic [2:0]        cnt_d;
  logic [7:0]        rx_q;
  logic [7:0]        tx_q;
  logic [7:0]        tx_d;
  logic [1:0]        busy_l_q;
  logic              sda_neg_q;
  logic              sda_oe_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] ptr_d;
  logic              wr_fire;
  logic              wr_tgl_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0]        wr_data_q;

  // ----------------------------------------------------------------
  // Serial clock domain: decode
  // ----------------------------------------------------------------
  // rx_q[0] is the level sampled at the last rising edge and sda_neg_q the
  // level at the following falling edge; a fall between them is a START.
  wire start_det  = rx_q[0] & ~sda_neg_q;
  wire busy_l     = busy_l_q[1];
  wire code_match = (rx_q[7:4] == CTRL_CODE);
  wire ctrl_hit   = code_match & ~busy_l;
  wire dir_read   = rx_q[0];
  wire in_ctrl_ack  = (state_q == ST_CTRL_ACK);
  wire in_addr_ack  = (state_q == ST_ADDR_ACK);
  wire in_wdata_ack = (state_q == ST_WDATA_ACK);
  wire in_rdata     = (state_q == ST_RDATA);
  wire in_rchk      = (state_q == ST_RCHK);
  wire ack_drive  = (in_ctrl_ack & ctrl_hit) | in_addr_ack | in_wdata_ack;
  wire rd_drive   = (in_rdata & ~tx_q[7])
                    | (in_rchk & ~rx_q[0] & ~tx_q[7]);
  wire sda_oe_d   = ack_drive | rd_drive;
  wire [7:0] tx_shift = {tx_q[6:0], 1'b0};
  wire [ADDR_W-1:0] ptr_inc = ptr_q + 1'b1;

  assign pif.rd_addr = ptr_q;
  assign pif.wr_tgl  = wr_tgl_q;
  assign pif.wr_addr = wr_addr_q;
  assign pif.wr_data = wr_data_q;
  assign o_sda_oe    = sda_oe_q;

  // ----------------------------------------------------------------
  // Serial clock domain: next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 3'h1;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    wr_fire = 1'b0;
    if (start_det) begin
      // Repeated START: this edge already carries the first control bit
      state_d = ST_CTRL;
      cnt_d   = BIT_FIRST;
    end else begin
      unique case (state_q)
        ST_CTRL: begin
          if (cnt_q == BIT_LAST) begin
            state_d = ST_CTRL_ACK;
          end
        end
        ST_ADDR: begin
          if (cnt_q == BIT_LAST) begin
            state_d = ST_ADDR_ACK;
          end
        end
        ST_WDATA: begin
          if (cnt_q == BIT_LAST) begin
            state_d = ST_WDATA_ACK;
          end
        end
        ST_CTRL_ACK: begin
          cnt_d = BIT_ZERO;
          if (!ctrl_hit) begin
            state_d = ST_IGNORE;
          end else if (dir_read) begin
            state_d = ST_RDATA;
            tx_d    = pif.rd_data;
          end else begin
            state_d = ST_ADDR;
          end
        end
        ST_ADDR_ACK: begin
          cnt_d   = BIT_ZERO;
          ptr_d   = rx_q[ADDR_W-1:0];
          state_d = ST_WDATA;
        end
        ST_WDATA_ACK: begin
          cnt_d   = BIT_ZERO;
          wr_fire = 1'b1;
          ptr_d   = ptr_inc;
          state_d = ST_WDATA;
        end
        ST_RDATA: begin
          tx_d = tx_shift;
          if (cnt_q == BIT_LAST) begin
            state_d = ST_RACK;
            ptr_d   = ptr_inc;
          end
        end
        ST_RACK: begin
          // Next byte is fetched now, sent only if the master acknowledged
          cnt_d   = BIT_ZERO;
          tx_d    = pif.rd_data;
          state_d = ST_RCHK;
        end
        ST_RCHK: begin
          if (rx_q[0]) begin
            state_d = ST_IGNORE;
          end else begin
            tx_d    = tx_shift;
            state_d = ST_RDATA;
          end
        end
        ST_IGNORE: begin
          state_d = ST_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: rising edge, frame state
  // ----------------------------------------------------------------
  always_ff @(posedge i_scl or posedge link_hold_q) begin
    if (link_hold_q) begin
      state_q  <= ST_CTRL;
      cnt_q    <= BIT_ZERO;
      rx_q     <= RX_RST;
      tx_q     <= RX_RST;
      busy_l_q <= 2'h0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      rx_q     <= {rx_q[6:0], i_sda};
      tx_q     <= tx_d;
      busy_l_q <= {busy_l_q[0], pif.busy};
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: rising edge, state that outlives a frame
  // ----------------------------------------------------------------
  // The pointer and the write toggle survive STOP; a toggle reset by the
  // frame would look like a spurious byte to the programming controller.
  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q     <= ADDR_W'(PTR_RST);
      wr_tgl_q  <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= 8'h00;
    end else begin
      ptr_q <= ptr_d;
      if (wr_fire) begin
        wr_tgl_q  <= ~wr_tgl_q;
        wr_addr_q <= ptr_q;
        wr_data_q <= rx_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: falling edge, pin drive
  // ----------------------------------------------------------------
  // Drive changes only while the clock is low, never making START/STOP.
  always_ff @(negedge i_scl or posedge link_hold_q) begin
    if (link_hold_q) begin
      sda_neg_q <= 1'b1;
      sda_oe_q  <= 1'b0;
    end else begin
      sda_neg_q <= i_sda;
      sda_oe_q  <= sda_oe_d;
    end
  end

endmodule : eep_core

// *** rtl/eep_pkg.sv ***
// Shared constants and types of the serial EEPROM slave.
// Assumes a 125 MHz system clock; no other surroundings needed.
package eep_pkg;

  // ----------------------------------------------------------------
  // Clock and write cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned TWR_MS     = 10;
  // Longest write time rounds down to whole cycles
  localparam int unsigned TWR_CYC    = (SYS_CLK_HZ / 1000) * TWR_MS;

  // ----------------------------------------------------------------
  // Array and control byte layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W_DEF = 8;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned PAGE_LEN   = 1 << PAGE_W;
  localparam logic [3:0]  CTRL_CODE  = 4'hA;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [2:0]  BIT_FIRST  = 3'h1;
  localparam logic [2:0]  BIT_ZERO   = 3'h0;
  localparam logic [7:0]  RX_RST     = 8'hFF;
  localparam logic [7:0]  PTR_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Link engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CTRL,
    ST_CTRL_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RCHK,
    ST_IGNORE
  } eep_state_t;

endpackage : eep_pkg

// *** rtl/eep_prog.sv ***
// Programming controller: page staging, self-timed write cycle, array.
// Runs on the system clock; write bytes arrive from the serial clock domain.
`timescale 1ns/1ns
module eep_prog
  import eep_pkg::*;
#(
  parameter int unsigned P_TWR_CYC = TWR_CYC,
  parameter int unsigned ADDR_W    = ADDR_W_DEF
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  eep_prog_if.prog  pif
);

  localparam int unsigned CNT_W = $clog2(P_TWR_CYC + 1);
  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam int unsigned HI_W  = ADDR_W - PAGE_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]          tg_q;
  logic                busy_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [PAGE_LEN-1:0] pend_v_q;
  logic [HI_W-1:0]     base_hi_q;
  logic [7:0]          pend_d_q [0:PAGE_LEN-1];
  logic [7:0]          mem_q    [0:DEPTH-1];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire              new_byte = tg_q[2] ^ tg_q[1];
  wire              take     = new_byte & ~busy_q;
  wire              first    = ~(|pend_v_q);
  wire [PAGE_W-1:0] idx      = pif.wr_addr[PAGE_W-1:0];
  wire              prog_go  = pif.stop & ~first & ~busy_q & ~pif.wp
                               & ~pif.supply_low;
  wire              done     = busy_q & (cnt_q == '0);
  wire              commit   = done & ~pif.supply_low;
  wire              drop     = done | (pif.stop & ~busy_q & ~prog_go);

  assign pif.busy    = busy_q;
  assign pif.rd_data = mem_q[pif.rd_addr];

  // ----------------------------------------------------------------
  // Byte arrival and write timer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tg_q <= 3'h0;
    end else begin
      tg_q <= {tg_q[1:0], pif.wr_tgl};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (prog_go) begin
      busy_q <= 1'b1;
      cnt_q  <= CNT_W'(P_TWR_CYC - 1);
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_v_q  <= '0;
      base_hi_q <= '0;
    end else if (drop) begin
      pend_v_q  <= '0;
    end else if (take) begin
      pend_v_q[idx] <= 1'b1;
      if (first) begin
        base_hi_q <= pif.wr_addr[ADDR_W-1:PAGE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Staging buffer and array, not reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (take) begin
      pend_d_q[idx] <= pif.wr_data;
    end
    for (int i = 0; i < PAGE_LEN; i++) begin
      if (commit && pend_v_q[i]) begin
        mem_q[{base_hi_q, PAGE_W'(i)}] <= pend_d_q[i];
      end
    end
  end

endmodule : eep_prog

// *** rtl/eep_prog_if.sv ***
// Bundle between the link engine and the programming controller.
// Write bytes travel with a toggle; the array read port is quasi-static.
`timescale 1ns/1ns
interface eep_prog_if #(
  parameter int unsigned ADDR_W = 8
);
  logic              wr_tgl;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              stop;
  logic              wp;
  logic              supply_low;
  logic              busy;

  modport prog (
    input  wr_tgl, wr_addr, wr_data, rd_addr, stop, wp, supply_low,
    output rd_data, busy
  );

  modport core (
    output wr_tgl, wr_addr, wr_data, rd_addr, stop, wp, supply_low,
    input  rd_data, busy
  );
endinterface : eep_prog_if

// *** verification/eep_core_asserts.sv ***
// Concurrent checks on the ports of the serial EEPROM slave top.
// Assumes a slow serial clock and a bench that waits out each write cycle.
`timescale 1ns/1ns
module eep_core_asserts
  import eep_pkg::*;
#(
  parameter int unsigned P_TWR_CYC = TWR_CYC,
  parameter int unsigned ADDR_W    = ADDR_W_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_supply_low,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  since_q;
  logic [3:0]  since_d;
  int unsigned busy_cnt_q;
  int unsigned busy_cnt_d;
  wire logic   stop_raw;

  // Raw STOP as seen on two samples of the system clock
  assign stop_raw   = i_scl && scl_q && i_sda && !sda_q;
  assign since_d    = stop_raw ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
  assign busy_cnt_d = o_busy ? busy_cnt_q + 1 : 0;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
      since_q    <= 4'hF;
      busy_cnt_q <= 0;
    end else begin
      scl_q      <= i_scl;
      sda_q      <= i_sda;
      since_q    <= since_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_drive_low_only: assert property (o_sda_o == 1'h0)
    else $error("data output value not low");
  a_no_ack_busy: assert property (o_busy |-> !o_sda_oe)
    else $error("data pulled low during write cycle");
  a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_q == P_TWR_CYC)
    else $error("write cycle length wrong");
  a_busy_holds: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("write cycle dropped early");
  a_busy_after_stop: assert property ($rose(o_busy) |-> since_q >= 4'h2 && since_q <= 4'hC)
    else $error("write cycle not started by stop");
  a_protect_no_cycle: assert property ($rose(o_busy) |-> !i_wp && !i_supply_low)
    else $error("write cycle while protected or supply low");
  a_oe_rise_clk_low: assert property ((i_scl && scl_q) |-> !$rose(o_sda_oe))
    else $error("data pulled low while clock high");
  a_release_stop: assert property (stop_raw |-> ##6 (!o_sda_oe) [*8])
    else $error("data not released after stop");
endmodule : eep_core_asserts

bind eep_core eep_core_asserts #(
  .P_TWR_CYC(P_TWR_CYC),
  .ADDR_W   (ADDR_W)
) chk_u (
  .i_sys_clk   (i_sys_clk),
  .i_rst_b     (i_rst_b),
  .i_scl       (i_scl),
  .i_sda       (i_sda),
  .i_wp        (i_wp),
  .i_supply_low(i_supply_low),
  .o_sda_o     (o_sda_o),
  .o_sda_oe    (o_sda_oe),
  .o_busy      (o_busy)
);

// *** verification/eep_core_test.sv ***
// Self-checking bench for the serial EEPROM slave top.
// Assumes the master model in its own file and the bound checker.
`timescale 1ns/1ns
module eep_core_test;
  localparam int unsigned TWR = 200;

  logic      i_sys_clk;
  logic      i_rst_b;
  logic      i_wp;
  logic      i_supply_low;
  wire logic scl;
  wire logic sda;
  wire logic sda_o;
  wire logic sda_oe;
  wire logic busy;
  wire logic m_oe;
  int        errors;
  int        total_checks;
  logic [7:0] mem_img [4] = '{8'h5A, 8'hC3, 8'h96, 8'hE1};

  // Open-drain wire with pull-up
  assign sda = ((sda_oe && !sda_o) || m_oe) ? 1'h0 : 1'h1;

  eep_core #(.P_TWR_CYC(TWR), .ADDR_W(8)) dut_u (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_scl       (scl),
    .i_sda       (sda),
    .i_wp        (i_wp),
    .i_supply_low(i_supply_low),
    .o_sda_o     (sda_o),
    .o_sda_oe    (sda_oe),
    .o_busy      (busy)
  );
  eep_master_model m_u (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task test_done;
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic see_busy(input int n, output logic hit);
    hit = 1'h0;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge i_sys_clk);
      #1 hit = (busy === 1'h1);
    end
  endtask : see_busy

  task automatic rd_at(input logic [7:0] a, output logic [7:0] d);
    logic k;
    m_u.start_cond();
    m_u.put_byte(8'hA0, k);
    m_u.put_byte(a, k);
    m_u.start_cond();
    m_u.put_byte(8'hA1, k);
    m_u.get_byte(1'h0, d);
    m_u.stop_cond();
  endtask : rd_at

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic write_poll;
    logic [5:0] acks;
    logic       ok;
    int         polls;
    m_u.start_cond();
    m_u.put_byte(8'hA0, acks[5]);
    m_u.put_byte(8'h10, acks[4]);
    for (int i = 0; i < 4; i++) m_u.put_byte(mem_img[i], acks[3-i]);
    m_u.stop_cond();
    chk("write acks", 8'h3F, {2'h0, acks});
    see_busy(20, ok);
    chk("cycle after stop", 8'h01, {7'h00, ok});
    if (ok !== 1'h1) test_done();
    polls = 0;
    ok = 1'h0;
    while (!ok && polls < 20) begin
      m_u.start_cond();
      m_u.put_byte(8'hA0, ok);
      m_u.stop_cond();
      polls++;
    end
    chk("refused polls", 8'h01, {7'h00, polls > 1});
    chk("poll ack", 8'h01, {7'h00, ok});
    if (ok !== 1'h1) test_done();
    chk("busy at ack", 8'h00, {7'h00, busy});
  endtask : write_poll

  task automatic seq_read;
    logic       k;
    logic [7:0] d [3];
    m_u.start_cond();
    m_u.put_byte(8'hA0, k);
    m_u.put_byte(8'h10, k);
    m_u.start_cond();
    m_u.put_byte(8'hA1, k);
    chk("read ctrl ack", 8'h01, {7'h00, k});
    for (int i = 0; i < 3; i++) m_u.get_byte(i < 2, d[i]);
    m_u.stop_cond();
    for (int i = 0; i < 3; i++) chk("sequential data", mem_img[i], d[i]);
    chk("released after stop", 8'h00, {7'h00, sda_oe});
    m_u.start_cond();
    m_u.put_byte(8'hAF, k);
    m_u.get_byte(1'h0, d[0]);
    m_u.stop_cond();
    chk("current address read", mem_img[3], d[0]);
  endtask : seq_read

  task automatic prot_case(input logic wp, input logic sl);
    logic [2:0] acks;
    logic       hit;
    logic [7:0] d;
    @(posedge i_sys_clk);
    i_wp         <= wp;
    i_supply_low <= sl;
    repeat (4) @(posedge i_sys_clk);
    m_u.start_cond();
    m_u.put_byte(8'hA0, acks[2]);
    m_u.put_byte(8'h10, acks[1]);
    m_u.put_byte(8'h00, acks[0]);
    m_u.stop_cond();
    chk("protected acks", 8'h07, {5'h00, acks});
    see_busy(40, hit);
    chk("no write cycle", 8'h00, {7'h00, hit});
    rd_at(8'h10, d);
    chk("array unchanged", mem_img[0], d);
    @(posedge i_sys_clk);
    i_wp         <= 1'h0;
    i_supply_low <= 1'h0;
  endtask : prot_case

  task automatic bad_code;
    logic [7:0] codes [3] = '{8'h50, 8'hB1, 8'h2E};
    logic [1:0] k;
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      m_u.start_cond();
      m_u.put_byte(codes[i], k[1]);
      m_u.put_byte(8'h10, k[0]);
      m_u.stop_cond();
      chk("foreign code acks", 8'h00, {6'h00, k});
    end
    rd_at(8'h11, d);
    chk("read after foreign", mem_img[1], d);
  endtask : bad_code

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk = 1'h0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #400000;
    errors++;
    test_done();
  end

  initial begin
    i_rst_b      = 1'h0;
    i_wp         = 1'h0;
    i_supply_low = 1'h0;
    errors       = 0;
    total_checks = 0;
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'h1;
    repeat (5) @(posedge i_sys_clk);
    write_poll();
    seq_read();
    prot_case(1'h1, 1'h0);
    prot_case(1'h0, 1'h1);
    bad_code();
    test_done();
  end
endmodule : eep_core_test

// *** verification/eep_master_model.sv ***
// Behavioural two-wire bus master driving clock and open-drain data.
// Assumes the data wire is resolved outside with a pull-up.
`timescale 1ns/1ns
module eep_master_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  initial begin
    o_scl    = 1'h1;
    o_sda_oe = 1'h0;
  end

  // Data moves mid low phase, is read at the clock rise; 32 ns per bit
  task automatic xfer_bit(input logic b, output logic s);
    #8 o_sda_oe = !b;
    #8 o_scl = 1'h1;
    s = i_sda;
    #16 o_scl = 1'h0;
  endtask : xfer_bit

  // Also serves as repeated start; the odd offset drifts clock phase
  task automatic start_cond;
    #3 o_sda_oe = 1'h0;
    #8 o_scl = 1'h1;
    #40 o_sda_oe = 1'h1;
    #40 o_scl = 1'h0;
  endtask : start_cond

  // Clock then stands still high until the next frame
  task automatic stop_cond;
    #8 o_sda_oe = 1'h1;
    #8 o_scl = 1'h1;
    #40 o_sda_oe = 1'h0;
    #40;
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
    xfer_bit(1'h1, s);
    ack = (s === 1'h0);
  endtask : put_byte

  task automatic get_byte(input logic ack_m, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer_bit(1'h1, d[i]);
    xfer_bit(!ack_m, s);
  endtask : get_byte
endmodule : eep_master_model
